// ### hdl/ipshr_top.sv
// Interrupt pin sensing, pending latch, priority resolve and halt release.
// Assumes CPU supplies halt request/mode, source levels, and acknowledges.
`timescale 1ns/100ps
// Contract
// - Request zero triggers on level or rising edge as chosen by software.
// - Requests one, two, three, four, six and eight trigger on rising edge only.
// - Requests five and seven trigger on rising or falling edge as chosen.
// - The nonmaskable input triggers on rising only or on both edges as chosen.
// - A nonmaskable or zero request during first-idle or stop entry is held pending.
// - Entry into second idle lets a qualifying interrupt release halt normally.
// - A new interrupt after halt entry releases halt; the highest level is served first.
// - Each maskable source has one of seven software levels that decide service order.
// - Nine CPU, twenty-six internal and ten external sources are handled.
// - Run, second idle, first idle and stop exist and each halt is released by interrupts.
module ipshr_top
  import ipshr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [IPSHR_N_EXT-1:0] ext_request_pins,
  input wire logic nmi_pin,
  input wire logic zero_level_mode,
  input wire logic [1:0] five_seven_falling,
  input wire logic nmi_both_edges,
  input wire logic [IPSHR_N_CPU-1:0] cpu_src,
  input wire logic [IPSHR_N_INT-1:0] internal_src,
  input wire logic [IPSHR_N_SRC*IPSHR_LVL_W-1:0] src_level,
  input wire logic [IPSHR_LVL_W-1:0] cpu_mask_level,
  input wire logic halt_req,
  input wire logic [1:0] halt_mode,
  input wire logic int_ack,
  output logic int_valid,
  output logic [IPSHR_SRC_W-1:0] int_id,
  output logic [IPSHR_LVL_W-1:0] int_level,
  output logic [1:0] cur_mode,
  output logic halt_release
);
  logic [IPSHR_N_EXT:0] ext_hit;
  logic [IPSHR_N_SRC-1:0] pend_r, pend_nxt, raw_src;
  ipshr_state_t st_r, st_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [1:0] ecnt_r, ecnt_nxt;
  logic [1:0] held_r, held_nxt;
  logic rel_r, rel_nxt;
  logic val_r, val_nxt;
  logic [IPSHR_SRC_W-1:0] id_r, id_nxt;
  logic [IPSHR_LVL_W-1:0] lvl_r, lvl_nxt;
  logic [IPSHR_SRC_W-1:0] best_id;
  logic [IPSHR_LVL_W-1:0] best_lvl;
  logic best_any, wake_any, held_window;
  // Sources that entry into first idle or stop holds back instead of waking on
  logic [IPSHR_N_SRC-1:0] hold_mask;
  // Pin vector keeps every sense instance inside a real index
  logic [IPSHR_N_EXT:0] pin_vec;
  // Effective level per source, nonmaskable forced to the top
  logic [IPSHR_LVL_W-1:0] lvl_of [IPSHR_N_SRC];

  assign pin_vec = {nmi_pin, ext_request_pins};

  genvar g;
  generate
    for (g = 0; g <= IPSHR_N_EXT; g++) begin : g_sense
      localparam bit IS_NMI = (g == IPSHR_N_EXT);
      localparam bit IS_57 = (g == 5) || (g == 7);
      ipshr_sense u_sense (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(pin_vec[g]),
        .edge_mode((g == 0) ? !zero_level_mode : 1'b1),
        .falling_sel(IS_57 ? five_seven_falling[(g == 5) ? 0 : 1] : 1'b0),
        .both_sel(IS_NMI ? nmi_both_edges : 1'b0),
        .req(ext_hit[g])
      );
    end
  endgenerate

  assign raw_src = {ext_hit[IPSHR_N_EXT], ext_hit[IPSHR_N_EXT-1:0], internal_src, cpu_src};

  generate
    for (g = 0; g < IPSHR_N_SRC; g++) begin : g_lvl
      assign lvl_of[g] = (g == IPSHR_NMI_IDX) ? IPSHR_LVL_MAX : src_level[g*IPSHR_LVL_W +: IPSHR_LVL_W];
    end
  endgenerate

  // Level mode on request zero keeps pending set while the pin stays high
  always_comb begin
    best_any = 1'b0;
    best_id = '0;
    best_lvl = IPSHR_LVL_OFF;
    for (int i = 0; i < IPSHR_N_SRC; i++) begin
      // Strictly greater keeps the lowest index on a tie, except that the nonmaskable source always wins
      if (pend_r[i] && (i == IPSHR_NMI_IDX || lvl_of[i] > cpu_mask_level)) begin
        if (!best_any || lvl_of[i] > best_lvl || i == IPSHR_NMI_IDX) begin
          best_any = 1'b1;
          best_id = IPSHR_SRC_W'(i);
          best_lvl = lvl_of[i];
        end
      end
    end
  end

  // Nmi and request zero arriving during first-idle/stop entry are latched but do not wake
  assign held_window = (st_r == IPSHR_ST_ENTER) && (mode_r != IPSHR_MODE_SECOND_IDLE_MODE);
  always_comb begin
    hold_mask = '0;
    hold_mask[IPSHR_NMI_IDX] = 1'b1;
    hold_mask[IPSHR_EXT_BASE] = 1'b1;
  end
  // Other sources still wake during the window, so only the two held ones can be stranded
  assign wake_any = held_window ? |(raw_src & ~hold_mask) : |raw_src;

  always_comb begin
    pend_nxt = pend_r | raw_src;
    st_nxt = st_r;
    mode_nxt = mode_r;
    ecnt_nxt = ecnt_r;
    held_nxt = held_r;
    rel_nxt = 1'b0;
    val_nxt = val_r;
    id_nxt = id_r;
    lvl_nxt = lvl_r;
    if (val_r && int_ack) begin
      pend_nxt[id_r] = raw_src[id_r];
      val_nxt = 1'b0;
    end else if (!val_r && best_any && st_r == IPSHR_ST_RUN) begin
      val_nxt = 1'b1;
      id_nxt = best_id;
      lvl_nxt = best_lvl;
    end
    unique case (st_r)
      IPSHR_ST_RUN: begin
        held_nxt = 2'b00;
        if (halt_req && halt_mode != IPSHR_MODE_RUN && !best_any) begin
          st_nxt = IPSHR_ST_ENTER;
          mode_nxt = halt_mode;
          ecnt_nxt = 2'(IPSHR_ENTRY_CYC - 1);
        end
      end
      IPSHR_ST_ENTER: begin
        if (held_window) begin
          held_nxt = held_r | {raw_src[IPSHR_NMI_IDX], ext_hit[0]};
        end
        if (wake_any) begin
          st_nxt = IPSHR_ST_RUN;
          mode_nxt = IPSHR_MODE_RUN;
          rel_nxt = 1'b1;
          held_nxt = 2'b00;
        end else if (ecnt_r == 2'h0) begin
          st_nxt = IPSHR_ST_HALT;
        end else begin
          ecnt_nxt = ecnt_r - 2'h1;
        end
      end
      IPSHR_ST_HALT: begin
        if (|raw_src) begin
          st_nxt = IPSHR_ST_RUN;
          mode_nxt = IPSHR_MODE_RUN;
          rel_nxt = 1'b1;
          held_nxt = 2'b00;
        end
      end
      default: begin
        st_nxt = IPSHR_ST_RUN;
        mode_nxt = IPSHR_MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
      st_r <= IPSHR_ST_RUN;
      mode_r <= IPSHR_MODE_RUN;
      ecnt_r <= 2'h0;
      held_r <= 2'b00;
      rel_r <= 1'b0;
      val_r <= 1'b0;
      id_r <= '0;
      lvl_r <= IPSHR_LVL_OFF;
    end else begin
      pend_r <= pend_nxt;
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      ecnt_r <= ecnt_nxt;
      held_r <= held_nxt;
      rel_r <= rel_nxt;
      val_r <= val_nxt;
      id_r <= id_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign int_valid = val_r;
  assign int_id = id_r;
  assign int_level = lvl_r;
  assign cur_mode = mode_r;
  assign halt_release = rel_r;

  AST_HELD_NO_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
    held_window && !(|(raw_src & ~hold_mask)) |=> !halt_release) else $error("Held request woke halt during entry");
  AST_HELD_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    held_window && ext_hit[0] |=> pend_r[IPSHR_EXT_BASE]) else $error("Held request zero not pending");
  AST_HELD_KEPT: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == IPSHR_ST_HALT && held_r[1] |-> pend_r[IPSHR_NMI_IDX]) else $error("Held nmi lost in halt");
  AST_HELD_PEND: assert property (@(posedge mclk) disable iff (!rst_n)
    held_window && raw_src[IPSHR_NMI_IDX] |=> pend_r[IPSHR_NMI_IDX]) else $error("Held nmi not pending");
  AST_SECOND_IDLE_MODE_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == IPSHR_ST_ENTER && mode_r == IPSHR_MODE_SECOND_IDLE_MODE && |raw_src |=> halt_release && st_r == IPSHR_ST_RUN)
    else $error("Second idle entry did not release");
  AST_HALT_WAKE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == IPSHR_ST_HALT && |raw_src |=> halt_release ##1 !halt_release) else $error("Halt not released");
  AST_ENTRY_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == IPSHR_ST_RUN ##1 st_r == IPSHR_ST_ENTER && mode_r == IPSHR_MODE_STOP && (raw_src & ~hold_mask) == '0 [*3]
    |=> st_r == IPSHR_ST_HALT) else $error("Entry window length wrong");
  AST_PRIO: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(int_valid) && int_id != IPSHR_SRC_W'(IPSHR_NMI_IDX) |-> int_level > cpu_mask_level)
    else $error("Granted level not above mask");
  AST_NMI_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(int_valid) && int_id == IPSHR_SRC_W'(IPSHR_NMI_IDX) |-> int_level == IPSHR_LVL_MAX)
    else $error("Nonmaskable grant not at top level");
  AST_ACK_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    int_valid && int_ack |=> !int_valid) else $error("Grant stayed after ack");
  // Every source, whatever its group, lands in pending
  AST_SRC_PEND: assert property (@(posedge mclk) disable iff (!rst_n)
    raw_src != '0 |=> (pend_r & $past(raw_src)) == $past(raw_src))
    else $error("Source request not pending");
  // Grants are only raised while running
  AST_NO_GRANT_HALT: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r != IPSHR_ST_RUN && !int_valid |=> !int_valid) else $error("Grant raised outside run");
  AST_HALT_MODE: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == IPSHR_ST_HALT |-> cur_mode != IPSHR_MODE_RUN) else $error("Halt with run mode");
  AST_REL_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    halt_release |-> cur_mode == IPSHR_MODE_RUN ##1 !halt_release) else $error("Release not a run pulse");
  AST_FIVE_EDGE: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_hit[5] |-> ($past(five_seven_falling[0])
      ? (!$past(g_sense[5].u_sense.s2_r) && $past(g_sense[5].u_sense.s3_r))
      : ($past(g_sense[5].u_sense.s2_r) && !$past(g_sense[5].u_sense.s3_r)))) else $error("Request five wrong edge");
  AST_SEVEN_EDGE: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_hit[7] |-> ($past(five_seven_falling[1])
      ? (!$past(g_sense[7].u_sense.s2_r) && $past(g_sense[7].u_sense.s3_r))
      : ($past(g_sense[7].u_sense.s2_r) && !$past(g_sense[7].u_sense.s3_r)))) else $error("Request seven wrong edge");
  AST_NMI_EDGE: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_hit[IPSHR_N_EXT] |-> ($past(nmi_both_edges)
      ? ($past(g_sense[IPSHR_N_EXT].u_sense.s2_r) != $past(g_sense[IPSHR_N_EXT].u_sense.s3_r))
      : ($past(g_sense[IPSHR_N_EXT].u_sense.s2_r) && !$past(g_sense[IPSHR_N_EXT].u_sense.s3_r))))
    else $error("Nonmaskable wrong edge");
  AST_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
    int_valid && !int_ack |=> int_valid && $stable(int_id)) else $error("Grant dropped before ack");
  AST_RISE_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_hit[1] |-> $past(g_sense[1].u_sense.s2_r) && !$past(g_sense[1].u_sense.s3_r))
    else $error("Request one fired without rising edge");
  AST_ZERO_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
    zero_level_mode && $past(zero_level_mode) |-> ext_hit[0] == $past(g_sense[0].u_sense.s2_r))
    else $error("Request zero level mode wrong");
  COV_HALT_WAKE: cover property (@(posedge mclk) disable iff (!rst_n) st_r == IPSHR_ST_HALT ##1 halt_release);
  COV_HELD: cover property (@(posedge mclk) disable iff (!rst_n) held_window && raw_src[IPSHR_NMI_IDX]);
  COV_SECOND_IDLE_MODE: cover property (@(posedge mclk) disable iff (!rst_n)
    st_r == IPSHR_ST_ENTER && mode_r == IPSHR_MODE_SECOND_IDLE_MODE ##1 halt_release);
  COV_GRANT: cover property (@(posedge mclk) disable iff (!rst_n) int_valid && int_ack);
  COV_STOP_HELD: cover property (@(posedge mclk) disable iff (!rst_n)
    held_window && mode_r == IPSHR_MODE_STOP && ext_hit[0]);
endmodule // ipshr_top

// ### hdl/ipshr_pkg.sv
// Constants and types for the interrupt pin sense and halt release block.
// Assumes one clock (mclk, 40 MHz); no software-reachable registers.
package ipshr_pkg;
  localparam int IPSHR_N_EXT = 9;
  localparam int IPSHR_N_CPU = 9;
  localparam int IPSHR_N_INT = 26;
  localparam int IPSHR_N_SRC = IPSHR_N_CPU + IPSHR_N_INT + IPSHR_N_EXT + 1;
  localparam int IPSHR_SRC_W = 6;
  localparam int IPSHR_LVL_W = 3;
  localparam logic [2:0] IPSHR_LVL_OFF = 3'h0;
  localparam logic [2:0] IPSHR_LVL_MAX = 3'h7;
  localparam int IPSHR_ENTRY_OSC_CYC = 3;
  localparam int IPSHR_ENTRY_CYC = IPSHR_ENTRY_OSC_CYC;
  localparam int IPSHR_EXT_BASE = IPSHR_N_CPU + IPSHR_N_INT;
  localparam int IPSHR_NMI_IDX = IPSHR_N_SRC - 1;
  typedef enum logic [1:0] {
    IPSHR_MODE_RUN = 2'b00,
    IPSHR_MODE_SECOND_IDLE_MODE = 2'b01,
    IPSHR_MODE_FIRST_IDLE_MODE = 2'b10,
    IPSHR_MODE_STOP = 2'b11
  } ipshr_mode_t;
  typedef enum logic [1:0] {
    IPSHR_ST_RUN = 2'b00,
    IPSHR_ST_ENTER = 2'b01,
    IPSHR_ST_HALT = 2'b10
  } ipshr_state_t;
endpackage

// ### hdl/ipshr_sense.sv
// One external interrupt pin: two-stage synchroniser and trigger detector.
// Assumes pin driven by outside logic, sampled on mclk.
`timescale 1ns/100ps
module ipshr_sense (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic edge_mode,
  input wire logic falling_sel,
  input wire logic both_sel,
  output logic req
);
  logic s1_r, s2_r, s3_r;
  logic s1_nxt, s2_nxt, s3_nxt, req_nxt;
  always_comb begin
    s1_nxt = pin;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    if (!edge_mode) begin
      req_nxt = s2_r;
    end else if (both_sel) begin
      req_nxt = s2_r ^ s3_r;
    end else if (falling_sel) begin
      req_nxt = !s2_r && s3_r;
    end else begin
      req_nxt = s2_r && !s3_r;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      req <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      req <= req_nxt;
    end
  end
endmodule // ipshr_sense

// ### testbench/ipshr_pin_driver.sv
// Model of the outside logic that drives the request pins and the nonmaskable pin.
// Assumes drive() is called just after a falling edge of mclk.
`timescale 1ns/100ps
module ipshr_pin_driver
  import ipshr_pkg::*;
(
  output logic [IPSHR_N_EXT-1:0] pins,
  output logic nmi
);
  initial begin
    pins = '0;
    nmi = 1'b0;
  end
  // Index IPSHR_N_EXT picks the nonmaskable pin
  task automatic drive(input int k, input logic v);
    if (k == IPSHR_N_EXT) begin
      nmi <= v;
    end else begin
      pins[k] <= v;
    end
  endtask
endmodule // ipshr_pin_driver

// ### testbench/ipshr_top_bench.sv
// Self-checking bench for pin sensing, halt release and priority order.
// Assumes the pin model drives the pins; inputs change at falling edges.
`timescale 1ns/100ps
module ipshr_top_bench;
  import ipshr_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, zlm = 1'b0, nbe = 1'b0, hreq = 1'b0, ack = 1'b0;
  logic [1:0] fsf = 2'h0, hmode = 2'h0, cur_mode;
  logic [IPSHR_N_EXT-1:0] pins;
  logic nmi, int_valid, halt_release;
  logic [IPSHR_N_SRC*IPSHR_LVL_W-1:0] lvls;
  logic [5:0] int_id;
  logic [2:0] int_level;
  int errors = 0, check_count = 0, cycles = 0;
  always #12.5 mclk = ~mclk;
  ipshr_pin_driver u_pins (.pins(pins), .nmi(nmi));
  ipshr_top u_dut (.mclk(mclk), .rst_n(rst_n), .ext_request_pins(pins), .nmi_pin(nmi),
    .zero_level_mode(zlm), .five_seven_falling(fsf), .nmi_both_edges(nbe), .cpu_src(9'h000),
    .internal_src(26'h000_0000), .src_level(lvls), .cpu_mask_level(3'h0), .halt_req(hreq),
    .halt_mode(hmode), .int_ack(ack), .int_valid(int_valid), .int_id(int_id),
    .int_level(int_level), .cur_mode(cur_mode), .halt_release(halt_release));
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic pin(input int k, input logic v);
    @(negedge mclk);
    u_pins.drive(k, v);
  endtask
  task automatic grant(input int id, input logic [2:0] lv);
    int n;
    n = 0;
    while (int_valid !== 1'b1 && n < 12) begin
      @(negedge mclk);
      n++;
    end
    check("int_valid", {7'h0, int_valid}, 8'h01);
    check("int_id", {2'h0, int_id}, 8'(id));
    check("int_level", {5'h0, int_level}, {5'h0, lv});
    ack = 1'b1;
    @(negedge mclk) ack = 1'b0;
    @(negedge mclk);
  endtask
  task automatic quiet();
    logic seen;
    seen = 1'b0;
    repeat (12) @(negedge mclk) if (int_valid !== 1'b0) seen = 1'b1;
    check("no_grant", {7'h0, seen}, 8'h00);
  endtask
  task automatic wait_release(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (10) @(negedge mclk) if (halt_release === 1'b1) seen = 1'b1;
    check("halt_release", {7'h0, seen}, {7'h0, exp});
  endtask
  // Rising-only pins fire once per edge, never on a held level or a fall
  task automatic t_rising();
    for (int k = 1; k < IPSHR_N_EXT; k++) begin
      if (k == 5 || k == 7) continue;
      pin(k, 1'b1);
      grant(IPSHR_EXT_BASE + k, (k == 1) ? 3'h3 : 3'h1);
      quiet();
      pin(k, 1'b0);
      quiet();
    end
  endtask
  task automatic t_level();
    zlm = 1'b1;
    pin(0, 1'b1);
    grant(IPSHR_EXT_BASE, 3'h1);
    grant(IPSHR_EXT_BASE, 3'h1);
    pin(0, 1'b0);
    repeat (8) @(negedge mclk) ack = (int_valid === 1'b1);
    ack = 1'b0;
    zlm = 1'b0;
    quiet();
  endtask
  task automatic t_five_seven();
    fsf = 2'h1;
    pin(5, 1'b1);
    quiet();
    pin(5, 1'b0);
    grant(IPSHR_EXT_BASE + 5, 3'h1);
    pin(7, 1'b1);
    grant(IPSHR_EXT_BASE + 7, 3'h1);
    pin(7, 1'b0);
    quiet();
    fsf = 2'h0;
  endtask
  task automatic t_nmi(input logic both);
    nbe = both;
    pin(IPSHR_N_EXT, 1'b1);
    grant(IPSHR_NMI_IDX, IPSHR_LVL_MAX);
    pin(IPSHR_N_EXT, 1'b0);
    if (both) grant(IPSHR_NMI_IDX, IPSHR_LVL_MAX);
    else quiet();
  endtask
  // Request lands inside the entry window; in first idle or stop held, then woken by pin one; in second idle it wakes directly
  task automatic t_halt(input logic [1:0] mode, input int k);
    @(negedge mclk);
    hmode = mode;
    hreq = 1'b1;
    u_pins.drive(k, 1'b1);
    @(negedge mclk) hreq = 1'b0;
    wait_release(mode == IPSHR_MODE_SECOND_IDLE_MODE);
    if (mode != IPSHR_MODE_SECOND_IDLE_MODE) begin
      check("cur_mode", {6'h0, cur_mode}, {6'h0, mode});
      pin(1, 1'b1);
      wait_release(1'b1);
      check("cur_mode", {6'h0, cur_mode}, 8'h00);
    end
    if (k == IPSHR_N_EXT) grant(IPSHR_NMI_IDX, IPSHR_LVL_MAX);
    if (mode != IPSHR_MODE_SECOND_IDLE_MODE) grant(IPSHR_EXT_BASE + 1, 3'h3);
    if (k == 0) grant(IPSHR_EXT_BASE, 3'h1);
    pin(k, 1'b0);
    pin(1, 1'b0);
    quiet();
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    for (int i = 0; i < IPSHR_N_SRC; i++) lvls[i*3 +: 3] = 3'h1;
    lvls[(IPSHR_EXT_BASE + 1)*3 +: 3] = 3'h3;
    lvls[IPSHR_NMI_IDX*3 +: 3] = IPSHR_LVL_MAX;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    check("int_valid_rst", {7'h0, int_valid}, 8'h00);
    t_rising();
    t_level();
    t_five_seven();
    t_nmi(1'b1);
    t_nmi(1'b0);
    t_halt(IPSHR_MODE_FIRST_IDLE_MODE, IPSHR_N_EXT);
    t_halt(IPSHR_MODE_STOP, 0);
    t_halt(IPSHR_MODE_SECOND_IDLE_MODE, IPSHR_N_EXT);
    stop_test();
  end
endmodule // ipshr_top_bench
